// ### hw/pci_config_status_register.sv
// Configuration status word with command word and interrupt pin gating
`timescale 1ns/1ns
// Contract
// [RQ1] Status word at offset 0x06, 16 bits, word access, resets to 0x0230
// [RQ2] Writing one clears a writable status bit; zero leaves it; never set
// [RQ3] Reserved bits 2..0 and 6 ignore writes; software writes zero
// [RQ4] Bit 3 mirrors internal interrupt pending, unmasked
// [RQ5] Interrupt pin active only while pending and mask bit zero
// [RQ6] Mask bit does not change the pending flag
// [RQ7] Bit 4 reads one: extended capability list present
// [RQ8] Bit 5 reads one: 66MHz bus clock supported
// [RQ9] Bit 7 read-only target fast back-to-back capability
// [RQ10] Conventional mode: master sees parity error with response enabled
// [RQ11] PCI-X: parity error on immediately completed read data sets bit 8
// [RQ12] PCI-X: parity error in split response sets bit 8
// [RQ13] PCI-X: parity error three clocks after write data phase sets bit 8
// [RQ14] Bits 10..9 read-only select speed, value one means medium
// [RQ15] Parity response enable, command bit 6, zero ignores parity errors
// [RQ16] Command bit 10 masks the interrupt pin
// [RQ17] Bit 8 sticky until written one; detection wins over clear
module pci_config_status_register
  import pci_status_pkg::*;
#(
  parameter logic TARGET_B2B = 1'b0,
  parameter logic [1:0] SEL_SPEED = 2'h1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration access
  input wire cfg_req_s cfg_req,
  output logic [15:0] cfg_rdata,
  // Device events
  input wire logic int_source,
  input wire parity_evt_s par_evt,
  input wire logic perr_seen,
  // Pins
  output logic inta_active
);

  logic [15:0] command_q;
  logic master_perr_q;
  logic int_pend_q;
  logic [PERR_LAG_CLOCKS-1:0] wr_phase_q;
  logic [15:0] status_view;
  logic par_resp;
  logic perr_hit;
  logic status_wr;
  logic command_wr;

  function automatic logic hit(input cfg_req_s r, input logic [7:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  assign status_wr = hit(cfg_req, STATUS_OFFSET);
  assign command_wr = hit(cfg_req, COMMAND_OFFSET);
  assign par_resp = command_q[PAR_RESP_BIT];

  // Status word assembly, reserved bits read zero
  always_comb begin
    status_view = 16'h0000;
    status_view[INT_PEND_BIT] = int_pend_q; // [RQ4]
    status_view[EXT_CAP_BIT] = STATUS_RESET[EXT_CAP_BIT]; // [RQ7]
    status_view[HIGH_SPEED_BIT] = STATUS_RESET[HIGH_SPEED_BIT]; // [RQ8]
    status_view[B2B_BIT] = TARGET_B2B; // [RQ9]
    status_view[MASTER_PERR_BIT] = master_perr_q;
    status_view[SEL_SPEED_LO+1:SEL_SPEED_LO] = SEL_SPEED; // [RQ14]
  end

  // Parity error detection in both bus modes
  always_comb begin
    perr_hit = 1'b0;
    if (par_resp) begin // [RQ15]
      if (!par_evt.pcix_mode) begin
        perr_hit = par_evt.conv_perr_seen; // [RQ10]
      end else begin
        perr_hit = par_evt.pcix_rd_imm_perr // [RQ11]
          || par_evt.pcix_split_perr // [RQ12]
          || (wr_phase_q[PERR_LAG_CLOCKS-1] && perr_seen); // [RQ13]
      end
    end
  end

  // Write data phase delay line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_phase_q <= '0;
    end else begin
      wr_phase_q <= {wr_phase_q[PERR_LAG_CLOCKS-2:0],
                     par_evt.pcix_wr_data_phase}; // [RQ13]
    end
  end

  // Command word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      command_q <= COMMAND_RESET;
    end else if (command_wr) begin
      command_q <= cfg_req.wdata & COMMAND_WMASK;
    end
  end

  // Sticky master parity error
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_perr_q <= STATUS_RESET[MASTER_PERR_BIT]; // [RQ1]
    end else if (perr_hit) begin
      master_perr_q <= 1'b1; // [RQ17]
    end else if (status_wr && cfg_req.wdata[MASTER_PERR_BIT]) begin
      master_perr_q <= 1'b0; // [RQ2] [RQ3]
    end
  end

  // Interrupt pending mirror
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_pend_q <= STATUS_RESET[INT_PEND_BIT];
    end else begin
      int_pend_q <= int_source; // [RQ6]
    end
  end

  function automatic logic command_wr_mask();
    command_wr_mask = command_wr ? cfg_req.wdata[INT_MASK_BIT]
                                 : command_q[INT_MASK_BIT];
  endfunction

  // Interrupt pin gating
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inta_active <= 1'b0;
    end else begin
      inta_active <= int_source && !command_wr_mask(); // [RQ5] [RQ16]
    end
  end

  // Read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_req.rd) begin
      case (cfg_req.addr)
        STATUS_OFFSET: cfg_rdata <= status_view; // [RQ1]
        COMMAND_OFFSET: cfg_rdata <= command_q;
        default: cfg_rdata <= 16'h0000;
      endcase
    end
  end

  // Assertions on reset and the register map
  status_rst_a: assert property (@(posedge mclk)
    $fell(rst) |-> cfg_rdata == 16'h0000) // [RQ1]
    else $error("read data not clear after reset");

  pin_rst_a: assert property (@(posedge mclk)
    $fell(rst) |-> !inta_active) // [RQ5]
    else $error("interrupt pin active after reset");

  status_rd_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == STATUS_OFFSET
    |=> cfg_rdata == $past(status_view)) // [RQ1]
    else $error("status read returned wrong word");

  unmapped_rd_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr != STATUS_OFFSET
    && cfg_req.addr != COMMAND_OFFSET
    |=> cfg_rdata == 16'h0000) // [RQ1]
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !cfg_req.rd |=> $stable(cfg_rdata)) // [RQ1]
    else $error("read data changed without read");

  cmd_write_a: assert property (@(posedge mclk) disable iff (rst)
    command_wr
    |=> command_q == ($past(cfg_req.wdata) & COMMAND_WMASK)) // [RQ16]
    else $error("command word write not applied");

  // Assertions on clearing and the sticky flag
  clear_one_a: assert property (@(posedge mclk) disable iff (rst)
    status_wr && cfg_req.wdata[MASTER_PERR_BIT] && !perr_hit
    |=> !master_perr_q) // [RQ2]
    else $error("write one did not clear parity flag");

  no_set_a: assert property (@(posedge mclk) disable iff (rst)
    !master_perr_q && !perr_hit |=> !master_perr_q) // [RQ2]
    else $error("parity flag set without event");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
    status_view[2:0] == 3'h0 && !status_view[6]) // [RQ3]
    else $error("reserved status bits not zero");

  sticky_win_a: assert property (@(posedge mclk) disable iff (rst)
    perr_hit && status_wr |=> master_perr_q) // [RQ17]
    else $error("clear beat simultaneous detection");

  // Assertions on the fixed capability bits
  fixed_bits_a: assert property (@(posedge mclk) disable iff (rst)
    status_view[5:4] == 2'h3 && status_view[10:9] == SEL_SPEED) // [RQ7]
    else $error("fixed capability bits wrong");

  hs_bit_a: assert property (@(posedge mclk) disable iff (rst)
    status_view[HIGH_SPEED_BIT] == STATUS_RESET[HIGH_SPEED_BIT]) // [RQ8]
    else $error("high speed bit wrong");

  b2b_bit_a: assert property (@(posedge mclk) disable iff (rst)
    status_view[B2B_BIT] == TARGET_B2B) // [RQ9]
    else $error("back to back bit wrong");

  sel_speed_a: assert property (@(posedge mclk) disable iff (rst)
    status_view[SEL_SPEED_LO+1:SEL_SPEED_LO] == SEL_SPEED) // [RQ14]
    else $error("select speed field wrong");

  // Assertions on the interrupt path
  pend_mirror_a: assert property (@(posedge mclk) disable iff (rst)
    ##1 int_pend_q == $past(int_source)) // [RQ4]
    else $error("pending flag not following source");

  mask_pend_a: assert property (@(posedge mclk) disable iff (rst)
    command_q[INT_MASK_BIT] && int_source |=> int_pend_q) // [RQ6]
    else $error("mask altered pending flag");

  pin_gate_a: assert property (@(posedge mclk) disable iff (rst)
    inta_active |-> int_pend_q && !command_q[INT_MASK_BIT]) // [RQ5]
    else $error("interrupt pin active while masked or idle");

  pin_on_a: assert property (@(posedge mclk) disable iff (rst)
    int_pend_q && !command_q[INT_MASK_BIT] |-> inta_active) // [RQ5]
    else $error("interrupt pin idle while pending");

  mask_pin_a: assert property (@(posedge mclk) disable iff (rst)
    command_q[INT_MASK_BIT] |-> !inta_active) // [RQ16]
    else $error("interrupt pin active while masked");

  // Assertions on parity error recording
  conv_perr_a: assert property (@(posedge mclk) disable iff (rst)
    !par_evt.pcix_mode && par_evt.conv_perr_seen && par_resp
    |=> master_perr_q) // [RQ10]
    else $error("conventional parity error not recorded");

  rd_imm_a: assert property (@(posedge mclk) disable iff (rst)
    par_evt.pcix_mode && par_evt.pcix_rd_imm_perr && par_resp
    |=> master_perr_q) // [RQ11]
    else $error("immediate read parity error not recorded");

  split_a: assert property (@(posedge mclk) disable iff (rst)
    par_evt.pcix_mode && par_evt.pcix_split_perr && par_resp
    |=> master_perr_q) // [RQ12]
    else $error("split response parity error not recorded");

  wr_lag_a: assert property (@(posedge mclk) disable iff (rst)
    par_evt.pcix_mode && par_resp && perr_seen
    && $past(par_evt.pcix_wr_data_phase, 3) |=> master_perr_q) // [RQ13]
    else $error("write parity error not recorded");

  wr_no_lag_a: assert property (@(posedge mclk) disable iff (rst)
    par_evt.pcix_mode && perr_seen && !master_perr_q
    && !$past(par_evt.pcix_wr_data_phase, 3)
    && !par_evt.pcix_rd_imm_perr && !par_evt.pcix_split_perr
    |=> !master_perr_q) // [RQ13]
    else $error("parity error outside write lag recorded");

  ignore_perr_a: assert property (@(posedge mclk) disable iff (rst)
    !par_resp |-> !perr_hit) // [RQ15]
    else $error("parity error acted on while disabled");

  // Covers for the main scenarios
  pin_on_c: cover property (@(posedge mclk) disable iff (rst)
    $rose(inta_active));

  perr_clear_c: cover property (@(posedge mclk) disable iff (rst)
    master_perr_q ##1 !master_perr_q);

  split_c: cover property (@(posedge mclk) disable iff (rst)
    par_evt.pcix_mode && par_evt.pcix_split_perr && par_resp);

  sticky_both_c: cover property (@(posedge mclk) disable iff (rst)
    perr_hit && status_wr && cfg_req.wdata[MASTER_PERR_BIT]);

  mask_block_c: cover property (@(posedge mclk) disable iff (rst)
    int_pend_q && command_q[INT_MASK_BIT] && !inta_active);

endmodule

// ### hw/pci_status_pkg.sv
// Constants and carriers for the configuration status word
package pci_status_pkg;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [15:0] STATUS_RESET = 16'h0230;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam int INT_PEND_BIT = 3;
  localparam int EXT_CAP_BIT = 4;
  localparam int HIGH_SPEED_BIT = 5;
  localparam int B2B_BIT = 7;
  localparam int MASTER_PERR_BIT = 8;
  localparam int SEL_SPEED_LO = 9;
  localparam int PAR_RESP_BIT = 6;
  localparam int INT_MASK_BIT = 10;
  localparam logic [15:0] COMMAND_WMASK = 16'h0557;
  localparam int PERR_LAG_CLOCKS = 3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic conv_perr_seen;
    logic pcix_mode;
    logic pcix_rd_imm_perr;
    logic pcix_split_perr;
    logic pcix_wr_data_phase;
  } parity_evt_s;
endpackage

// ### tb/cfg_host_model.sv
// Host model issuing configuration accesses
`timescale 1ns/1ns
module cfg_host_model
  import pci_status_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Access
  output cfg_req_s cfg_req,
  input wire logic [15:0] cfg_rdata
);
  initial cfg_req = '0;
  task automatic access(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    cfg_req <= '{!w, w, a, (a == STATUS_OFFSET) ? d & 16'hFFB8 : d};
    @(posedge mclk);
    cfg_req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = cfg_rdata;
  endtask
endmodule

// ### tb/tb_pci_config_status_register.sv
// Self-checking bench for the configuration status word
`timescale 1ns/1ns
module tb_pci_config_status_register;
  import pci_status_pkg::*;
  logic mclk = 0, rst = 1, int_source = 0, perr_seen = 0, inta_active;
  cfg_req_s cfg_req;
  parity_evt_s par_evt = '0;
  logic [15:0] cfg_rdata, q, cmd, w;
  logic [31:0] seed = 32'h0000C09D;
  int miscompares = 0, checked = 0, perr = 0;
  always #2 mclk = ~mclk;
  pci_config_status_register #(.TARGET_B2B(1'b0)) dut(.mclk(mclk),
    .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .int_source(int_source), .par_evt(par_evt), .perr_seen(perr_seen),
    .inta_active(inta_active));
  cfg_host_model host(.mclk(mclk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] stat();
    return 16'h0230 | {7'h00, perr[0], 4'h0, int_source, 3'h0};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fire(input logic [1:0] k);
    @(posedge mclk);
    par_evt <= '{k == 0, k != 0, k == 1, k == 2, k == 3};
    @(posedge mclk);
    par_evt <= '{1'b0, k != 0, 1'b0, 1'b0, 1'b0};
    repeat (2) @(posedge mclk);
    perr_seen <= (k == 3);
    @(posedge mclk);
    perr_seen <= 1'b0;
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    host.access(0, STATUS_OFFSET, 0, q);
    check(q, 16'h0230);
    host.access(0, 8'h08, 0, q);
    check(q, 16'h0000);
    $display("test 1 done");
    @(posedge mclk);
    int_source <= 1'b1;
    @(posedge mclk);
    #1;
    check({15'h0000, inta_active}, 16'h0001);
    host.access(1, COMMAND_OFFSET, 16'h0400, q);
    check({15'h0000, inta_active}, 16'h0000);
    host.access(1, STATUS_OFFSET, 16'hFEB8, q);
    host.access(0, STATUS_OFFSET, 0, q);
    check(q, stat());
    $display("test 2 done");
    for (int i = 0; i < 8; i++) begin
      cmd = rnd() & COMMAND_WMASK & 16'hFBBF | 16'(i[0]) << PAR_RESP_BIT;
      host.access(1, COMMAND_OFFSET, cmd, q);
      host.access(0, COMMAND_OFFSET, 0, q);
      check(q, cmd);
      fire(i[2:1]);
      perr = perr | i[0];
      host.access(0, STATUS_OFFSET, 0, q);
      check(q, stat());
      w = rnd();
      host.access(1, STATUS_OFFSET, w, q);
      perr = perr & !w[8];
      host.access(0, STATUS_OFFSET, 0, q);
      check(q, stat());
    end
    $display("test 3 done");
    stop_test();
  end
endmodule
